// *** adcsq_pkg.sv ***
package adcsq_pkg;
    // ===========================================
    // register map of the plain register port
    localparam logic [3:0] ADCSQ_OFS_STATUS = 4'h0;
    localparam logic [3:0] ADCSQ_OFS_DATA = 4'h1;
    localparam logic [3:0] ADCSQ_OFS_CTRL = 4'h2;
    localparam logic [3:0] ADCSQ_OFS_TEMP = 4'h3;
    localparam logic [3:0] ADCSQ_OFS_FLAGS = 4'h4;
    // ===========================================
    // status register fields
    localparam int ADCSQ_ST_IDX_LSB = 0;
    localparam int ADCSQ_ST_CFG_BIT = 5;
    localparam int ADCSQ_ST_CONV_BIT = 6;
    localparam int ADCSQ_ST_AVG_BIT = 7;
    // control register fields
    localparam int ADCSQ_CN_LOC_BIT = 0;
    // slot configuration fields
    localparam int ADCSQ_CF_CH_LSB = 0;
    localparam int ADCSQ_CF_DIFF_BIT = 5;
    localparam int ADCSQ_CF_ALIGN_BIT = 6;
    localparam int ADCSQ_CF_ACQ_BIT = 7;
    localparam int ADCSQ_CF_ALT_LSB = 8;
    localparam int ADCSQ_CF_GAIN_LSB = 13;
    // temperature control fields
    localparam int ADCSQ_TC_EN_BIT = 0;
    localparam int ADCSQ_TC_ALIGN_BIT = 4;
    localparam int ADCSQ_TC_IEN_BIT = 10;
    localparam logic [15:0] ADCSQ_TC_MASK = 16'h0411;
    localparam logic [15:0] ADCSQ_CF_MASK = 16'h7FFF;
    localparam logic [15:0] ADCSQ_ST_MASK = 16'h00FF;
    // ===========================================
    // sizes and reset values
    localparam int ADCSQ_NSLOT = 24;
    localparam int ADCSQ_NBUF = 25;
    localparam logic [4:0] ADCSQ_TEMP_ENTRY = 5'h16;
    localparam logic [15:0] ADCSQ_RST16 = 16'h0000;
    // channel codes
    localparam logic [4:0] ADCSQ_CH_LAST_DIFF = 5'h07;
    localparam logic [4:0] ADCSQ_CH_LAST_SINGLE = 5'h0F;
    localparam logic [4:0] ADCSQ_CH_REF_A = 5'h10;
    localparam logic [4:0] ADCSQ_CH_REF_B = 5'h11;
    localparam logic [4:0] ADCSQ_CH_SUPPLY = 5'h12;
    localparam logic [4:0] ADCSQ_CH_DAC_REF = 5'h13;
    localparam logic [4:0] ADCSQ_CH_OFFSET = 5'h19;
    // ===========================================
    // timing at 125 MHz
    localparam int ADCSQ_CLK_MHZ = 125;
    localparam int ADCSQ_TEMP_US = 42;
    localparam int ADCSQ_TEMP_CYC = ADCSQ_TEMP_US * ADCSQ_CLK_MHZ;
    localparam int ADCSQ_ACQ_EXT_CYC = 16;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } adcsq_bus_t;

    typedef struct packed {
        logic valid;
        logic [13:0] value;
    } adcsq_result_t;

    typedef struct packed {
        logic start;
        logic [4:0] channel;
        logic diff;
        logic [1:0] gain;
        logic [1:0] sample_average_count;
    } adcsq_req_t;
endpackage : adcsq_pkg

// *** adcsq_top.sv ***
// Operation
// - with override on, results go to the slot's alternate entry
// - acquisition extension bit adds a wait before that conversion
// - alignment one: result in bits 15:2, low two bits zero
// - alignment zero: result in bits 13:0, top bits copy bit 13
// - differential bit picks differential, else single-ended against ground
// - codes 0-15 single inputs; differential 0-7 pairs, 8-15 invalid
// - codes 16-19 references and supply, 25 offset, 20-24 invalid
// - averaging view write updates indexed averaging register, index advances
// - averaging registers reset to zero
// - averaging writes taken only while no conversion runs
// - averaging field codes one, four, eight, sixteen samples
// - result view read returns indexed 14-bit signed entry of 25
// - index increments after each result read
// - result entries reset to zero and ignore software writes
// - voltage and temperature formats, left shift by two positions
// - results are two's complement
// - die temperature results only go to entry 22
// - temperature interrupt raised on completion when enabled
// - temperature alignment bit picks left or right justification
// - writing temperature enable starts a 42 us conversion into entry 22
// - two-bit gain field selects one of four scale trims
// - index with view bits picks data port target, advances on access
// - temperature ready flag set on finish, cleared by writing zero
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // register port
    input wire adcsq_pkg::adcsq_bus_t bus_in,
    output logic [15:0] rdata_out,
    // converter side
    output adcsq_pkg::adcsq_req_t conv_req_out,
    input wire adcsq_pkg::adcsq_result_t conv_res_in,
    output logic temp_start_out,
    input wire adcsq_pkg::adcsq_result_t temp_res_in,
    // status
    output logic channel_invalid_out,
    output logic temp_irq_out
);
    import adcsq_pkg::*;

    typedef enum logic [2:0] {
        ADCSQ_IDLE = 3'b001,
        ADCSQ_ACQ = 3'b010,
        ADCSQ_CONV = 3'b100
    } adcsq_state_t;

    typedef struct packed {
        adcsq_state_t st;
        logic [ADCSQ_NSLOT-1:0][15:0] cfg;
        logic [ADCSQ_NSLOT-1:0][1:0] sample_average_count;
        logic [ADCSQ_NBUF-1:0][15:0] buf_e;
        logic [4:0] idx;
        logic cfg_view;
        logic avg_view;
        logic conv;
        logic location_override_enable;
        logic [4:0] slot;
        logic [4:0] acq_cnt;
        logic temp_ien;
        logic temp_align;
        logic temp_busy;
        logic temp_flag;
        logic [15:0] rdata;
        adcsq_req_t req;
        logic temp_start;
        logic invalid;
        logic irq;
    } adcsq_state_all_t;

    adcsq_state_all_t s_q, s_d;

    // ===========================================
    // helper functions
    function automatic logic [15:0] adcsq_align(input logic [13:0] v,
                                                input logic left);
        // both formats are 14-bit two's complement
        if (left) begin
            adcsq_align = {v, 2'b00};
        end else begin
            adcsq_align = {{2{v[13]}}, v};
        end
    endfunction : adcsq_align

    function automatic logic adcsq_bad_ch(input logic [4:0] ch,
                                          input logic diff);
        if (ch <= ADCSQ_CH_LAST_SINGLE) begin
            adcsq_bad_ch = diff && (ch > ADCSQ_CH_LAST_DIFF);
        end else begin
            adcsq_bad_ch = (ch > ADCSQ_CH_DAC_REF) &&
                           (ch != ADCSQ_CH_OFFSET);
        end
    endfunction : adcsq_bad_ch

    // ===========================================
    // next state
    logic [15:0] cur_cfg;
    logic [4:0] dest;
    logic port_hit;
    always_comb begin
        s_d = s_q;
        s_d.temp_start = 1'b0;
        s_d.req.start = 1'b0;
        s_d.rdata = ADCSQ_RST16;
        cur_cfg = s_q.cfg[s_q.slot];
        port_hit = bus_in.addr == ADCSQ_OFS_DATA;

        // register writes
        if (bus_in.wr) begin
            case (bus_in.addr)
                ADCSQ_OFS_STATUS: begin
                    s_d.idx = bus_in.wdata[ADCSQ_ST_IDX_LSB +: 5];
                    s_d.cfg_view = bus_in.wdata[ADCSQ_ST_CFG_BIT];
                    s_d.avg_view = bus_in.wdata[ADCSQ_ST_AVG_BIT];
                    s_d.conv = bus_in.wdata[ADCSQ_ST_CONV_BIT];
                    if (bus_in.wdata[ADCSQ_ST_CONV_BIT] && !s_q.conv) begin
                        s_d.slot = 5'h00;
                        s_d.st = ADCSQ_IDLE;
                    end
                end
                ADCSQ_OFS_DATA: begin
                    // writes land only while no conversion runs; the index moves anyway
                    if (s_q.cfg_view && !s_q.conv &&
                        s_q.idx < 5'(ADCSQ_NSLOT)) begin
                        s_d.cfg[s_q.idx] = bus_in.wdata & ADCSQ_CF_MASK;
                    end else if (!s_q.cfg_view && s_q.avg_view &&
                                 !s_q.conv &&
                                 s_q.idx < 5'(ADCSQ_NSLOT)) begin
                        s_d.sample_average_count[s_q.idx] = bus_in.wdata[1:0];
                    end
                    s_d.idx = s_q.idx + 5'h01;
                end
                ADCSQ_OFS_CTRL: begin
                    s_d.location_override_enable = bus_in.wdata[ADCSQ_CN_LOC_BIT];
                end
                ADCSQ_OFS_TEMP: begin
                    s_d.temp_ien = bus_in.wdata[ADCSQ_TC_IEN_BIT];
                    s_d.temp_align = bus_in.wdata[ADCSQ_TC_ALIGN_BIT];
                    if (bus_in.wdata[ADCSQ_TC_EN_BIT] && !s_q.temp_busy) begin
                        s_d.temp_busy = 1'b1;
                        s_d.temp_start = 1'b1;
                    end
                end
                ADCSQ_OFS_FLAGS: begin
                    if (!bus_in.wdata[1]) begin
                        s_d.temp_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads, data one cycle later
        if (bus_in.rd) begin
            case (bus_in.addr)
                ADCSQ_OFS_STATUS: begin
                    s_d.rdata = {8'h00, s_q.avg_view, s_q.conv,
                                 s_q.cfg_view, s_q.idx};
                end
                ADCSQ_OFS_DATA: begin
                    if (s_q.cfg_view) begin
                        if (s_q.idx < 5'(ADCSQ_NSLOT)) begin
                            s_d.rdata = s_q.cfg[s_q.idx];
                        end
                    end else if (s_q.avg_view) begin
                        if (s_q.idx < 5'(ADCSQ_NSLOT)) begin
                            s_d.rdata = {14'h0000, s_q.sample_average_count[s_q.idx]};
                        end
                    end else if (s_q.idx < 5'(ADCSQ_NBUF)) begin
                        s_d.rdata = s_q.buf_e[s_q.idx];
                    end
                    s_d.idx = s_q.idx + 5'h01;
                end
                ADCSQ_OFS_CTRL: begin
                    s_d.rdata = {15'h0000, s_q.location_override_enable};
                end
                ADCSQ_OFS_TEMP: begin
                    s_d.rdata = {5'h00, s_q.temp_ien, 5'h00, s_q.temp_align,
                                 3'h0, s_q.temp_busy};
                end
                ADCSQ_OFS_FLAGS: begin
                    s_d.rdata = {14'h0000, s_q.temp_flag, 1'b0};
                end
                default: begin
                end
            endcase
        end

        // ===========================================
        // slot sequencer, walks all slots once per start
        dest = s_q.location_override_enable ? cur_cfg[ADCSQ_CF_ALT_LSB +: 5]
                           : cur_cfg[ADCSQ_CF_CH_LSB +: 5];
        case (s_q.st)
            ADCSQ_IDLE: begin
                if (s_q.conv) begin
                    s_d.invalid = adcsq_bad_ch(cur_cfg[4:0],
                                               cur_cfg[ADCSQ_CF_DIFF_BIT]);
                    s_d.acq_cnt = cur_cfg[ADCSQ_CF_ACQ_BIT] ?
                                  5'(ADCSQ_ACQ_EXT_CYC) : 5'h00;
                    s_d.st = ADCSQ_ACQ;
                end
            end
            ADCSQ_ACQ: begin
                if (!s_q.conv) begin
                    s_d.st = ADCSQ_IDLE; // stop at once during acquisition
                end else if (s_q.acq_cnt != 5'h00) begin
                    s_d.acq_cnt = s_q.acq_cnt - 5'h01;
                end else begin
                    s_d.req.start = 1'b1;
                    s_d.req.channel = cur_cfg[ADCSQ_CF_CH_LSB +: 5];
                    s_d.req.diff = cur_cfg[ADCSQ_CF_DIFF_BIT];
                    s_d.req.gain = cur_cfg[ADCSQ_CF_GAIN_LSB +: 2];
                    s_d.req.sample_average_count = (cur_cfg[4:0] < 5'(ADCSQ_NSLOT)) ?
                                  s_q.sample_average_count[cur_cfg[4:0]] : 2'b00;
                    s_d.st = ADCSQ_CONV;
                end
            end
            ADCSQ_CONV: begin
                if (conv_res_in.valid) begin
                    // the reserved temperature entry is never overwritten
                    if (dest < 5'(ADCSQ_NBUF) && dest != ADCSQ_TEMP_ENTRY) begin
                        s_d.buf_e[dest] = adcsq_align(conv_res_in.value,
                            cur_cfg[ADCSQ_CF_ALIGN_BIT]);
                    end
                    if (s_q.slot == 5'(ADCSQ_NSLOT - 1)) begin
                        s_d.conv = 1'b0;
                        s_d.slot = 5'h00;
                    end else begin
                        s_d.slot = s_q.slot + 5'h01;
                    end
                    s_d.st = ADCSQ_IDLE;
                end
            end
            default: begin
                s_d.st = ADCSQ_IDLE;
            end
        endcase

        // ===========================================
        // die temperature completion
        if (s_q.temp_busy && temp_res_in.valid) begin
            s_d.temp_busy = 1'b0;
            s_d.buf_e[ADCSQ_TEMP_ENTRY] = adcsq_align(temp_res_in.value,
                s_q.temp_align);
            s_d.temp_flag = 1'b1;
        end
        s_d.irq = s_q.temp_flag && s_q.temp_ien;
    end

    // ===========================================
    // state register; all storage clears on reset
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
            s_q.st <= ADCSQ_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out = s_q.rdata;
    assign conv_req_out = s_q.req;
    assign temp_start_out = s_q.temp_start;
    assign channel_invalid_out = s_q.invalid;
    assign temp_irq_out = s_q.irq;

    // ===========================================
    // checks; one clock domain, so clock and reset are given once
    default clocking adcsq_cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    idx_advance_a: assert property (
        (bus_in.rd && port_hit) |=>
        s_q.idx == $past(s_q.idx) + 5'h01)
        else $error("index did not advance on read");
    index_write_a: assert property (
        (bus_in.wr && port_hit) |=>
        s_q.idx == $past(s_q.idx) + 5'h01)
        else $error("index did not advance on write");
    avg_locked_a: assert property (
        (bus_in.wr && port_hit && s_q.conv) |=>
        s_q.sample_average_count == $past(s_q.sample_average_count))
        else $error("averaging written during conversion");
    avg_write_a: assert property (
        (bus_in.wr && port_hit && s_q.avg_view && !s_q.cfg_view &&
         !s_q.conv && s_q.idx == 5'h00) |=>
        s_q.sample_average_count[0] == $past(bus_in.wdata[1:0]))
        else $error("averaging write lost");
    avg_read_a: assert property (
        (bus_in.rd && port_hit && s_q.avg_view && !s_q.cfg_view &&
         s_q.idx < 5'(ADCSQ_NSLOT)) |=>
        rdata_out == {14'h0000, $past(s_q.sample_average_count[s_q.idx])})
        else $error("averaging register not readable");
    avg_pass_a: assert property (
        (conv_req_out.start && cur_cfg[4:0] < 5'(ADCSQ_NSLOT)) |->
        conv_req_out.sample_average_count == s_q.sample_average_count[cur_cfg[4:0]])
        else $error("averaging count not passed on");
    result_read_a: assert property (
        (bus_in.rd && port_hit && !s_q.avg_view && !s_q.cfg_view &&
         s_q.idx < 5'(ADCSQ_NBUF)) |=>
        rdata_out == $past(s_q.buf_e[s_q.idx]))
        else $error("result read returned wrong entry");
    read_quiet_a: assert property (
        !bus_in.rd |=> rdata_out == ADCSQ_RST16)
        else $error("read data stood too long");
    ro_buffer_a: assert property (
        (bus_in.wr && !(s_q.st == ADCSQ_CONV && conv_res_in.valid) &&
         !(s_q.temp_busy && temp_res_in.valid)) |=> $stable(s_q.buf_e))
        else $error("software write altered results");
    temp_only_a: assert property (
        !(s_q.temp_busy && temp_res_in.valid) |=>
        $stable(s_q.buf_e[ADCSQ_TEMP_ENTRY]))
        else $error("temperature entry overwritten");
    // a fixed entry keeps the check apart from the design's own dest
    result_store_a: assert property (
        (s_q.st == ADCSQ_CONV && conv_res_in.valid &&
         (s_q.location_override_enable ? cur_cfg[ADCSQ_CF_ALT_LSB +: 5]
                      : cur_cfg[ADCSQ_CF_CH_LSB +: 5]) == 5'h03) |=>
        s_q.buf_e[3] == adcsq_align($past(conv_res_in.value),
                                    $past(cur_cfg[ADCSQ_CF_ALIGN_BIT])))
        else $error("result stored in wrong entry");
    seq_end_a: assert property (
        (s_q.st == ADCSQ_CONV && conv_res_in.valid &&
         s_q.slot == 5'(ADCSQ_NSLOT - 1)) |=> !s_q.conv)
        else $error("conversion bit kept after last slot");
    req_fields_a: assert property (
        conv_req_out.start |->
        conv_req_out.channel == cur_cfg[ADCSQ_CF_CH_LSB +: 5] &&
        conv_req_out.diff == cur_cfg[ADCSQ_CF_DIFF_BIT] &&
        conv_req_out.gain == cur_cfg[ADCSQ_CF_GAIN_LSB +: 2])
        else $error("conversion request fields wrong");
    bad_code_a: assert property (
        conv_req_out.start |-> channel_invalid_out ==
        ((cur_cfg[ADCSQ_CF_DIFF_BIT] && cur_cfg[4:3] == 2'b01) ||
         (cur_cfg[4:0] > ADCSQ_CH_DAC_REF &&
          cur_cfg[4:0] != ADCSQ_CH_OFFSET)))
        else $error("channel code validity wrong");
    acq_wait_a: assert property (
        (s_q.st == ADCSQ_IDLE && s_q.conv && cur_cfg[ADCSQ_CF_ACQ_BIT] &&
         !(bus_in.wr && bus_in.addr == ADCSQ_OFS_STATUS)) |=>
        !conv_req_out.start [*2])
        else $error("acquisition extension skipped");
    acq_plain_a: assert property (
        (s_q.st == ADCSQ_IDLE && s_q.conv && !cur_cfg[ADCSQ_CF_ACQ_BIT] &&
         !(bus_in.wr && bus_in.addr == ADCSQ_OFS_STATUS)) |->
        ##2 conv_req_out.start)
        else $error("acquisition time added without extension");
    temp_start_a: assert property (
        (bus_in.wr && bus_in.addr == ADCSQ_OFS_TEMP &&
         bus_in.wdata[ADCSQ_TC_EN_BIT] && !s_q.temp_busy) |=>
        temp_start_out && s_q.temp_busy)
        else $error("temperature conversion not started");
    temp_flag_a: assert property (
        (s_q.temp_busy && temp_res_in.valid) |=> s_q.temp_flag)
        else $error("temperature flag not set");
    flag_clear_a: assert property (
        (bus_in.wr && bus_in.addr == ADCSQ_OFS_FLAGS && !bus_in.wdata[1] &&
         !(s_q.temp_busy && temp_res_in.valid)) |=> !s_q.temp_flag)
        else $error("temperature flag not cleared");
    temp_irq_a: assert property (
        (s_q.temp_flag && s_q.temp_ien) |=> temp_irq_out)
        else $error("temperature interrupt missing");
    left_pad_a: assert property (
        (s_q.temp_busy && temp_res_in.valid && s_q.temp_align) |=>
        s_q.buf_e[ADCSQ_TEMP_ENTRY][1:0] == 2'b00)
        else $error("left alignment pad not zero");
    right_sign_a: assert property (
        (s_q.temp_busy && temp_res_in.valid && !s_q.temp_align) |=>
        s_q.buf_e[ADCSQ_TEMP_ENTRY][15:13] ==
        {3{$past(temp_res_in.value[13])}})
        else $error("right alignment sign wrong");
endmodule : adcsq_top
`default_nettype wire

// *** adcsq_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adcsq_pkg::*;
    // ===========================================
    // design and stimulus signals
    logic clk_in;
    logic reset_n_in;
    adcsq_bus_t bus_in;
    logic [15:0] rdata_out;
    adcsq_req_t conv_req_out;
    adcsq_result_t conv_res_in;
    logic temp_start_out;
    adcsq_result_t temp_res_in;
    logic channel_invalid_out;
    logic temp_irq_out;
    int error_cnt;
    int n_tests;
    int seed;
    logic [15:0] cfg_m [ADCSQ_NSLOT];
    logic [1:0] avg_m [ADCSQ_NSLOT];
    logic [15:0] buf_m [ADCSQ_NBUF];
    logic care [ADCSQ_NBUF];
    logic [15:0] v16;

    adcsq_top adcsq_top_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .bus_in(bus_in), .rdata_out(rdata_out),
        .conv_req_out(conv_req_out), .conv_res_in(conv_res_in),
        .temp_start_out(temp_start_out), .temp_res_in(temp_res_in),
        .channel_invalid_out(channel_invalid_out),
        .temp_irq_out(temp_irq_out));

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // ===========================================
    // expectations
    function automatic logic [15:0] fmt(input logic [13:0] v,
                                        input logic al);
        return al ? {v, 2'b00} : {{2{v[13]}}, v};
    endfunction : fmt
    function automatic logic bad(input logic [4:0] ch, input logic df);
        return (df && ch >= 5'h08 && ch <= 5'h0F) ||
               (ch >= 5'h14 && ch <= 5'h18) || ch > 5'h19;
    endfunction : bad
    // ===========================================
    // bus and compare tasks
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus_in.wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus_in.rd <= 1'b0;
        #1;
        d = rdata_out;
    endtask : rd
    task automatic rdc(input string n, input logic [15:0] e);
        logic [15:0] d;
        rd(ADCSQ_OFS_DATA, d);
        chk(n, e, d);
    endtask : rdc
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    // ===========================================
    // one pass over all slots; gaps tie acquisition extension to timing
    task automatic pass(input logic ovr, input logic [15:0] st);
        int gap;
        int g0;
        logic [4:0] dst;
        logic [13:0] v;
        g0 = -1;
        wr(ADCSQ_OFS_CTRL, {15'h0000, ovr});
        wr(ADCSQ_OFS_STATUS, st);
        for (int s = 0; s < ADCSQ_NSLOT; s++) begin
            gap = 0;
            while (conv_req_out.start !== 1'b1 && gap < 300) begin
                @(posedge clk_in);
                #1;
                gap++;
            end
            if (s > 0 && !cfg_m[s][7] && g0 < 0) g0 = gap;
            if (s > 0 && g0 >= 0)
                chk("gap", 16'(g0 + 16 * cfg_m[s][7]), 16'(gap));
            chk("request", {8'h00, cfg_m[s][14:13], cfg_m[s][5],
                cfg_m[s][4:0]}, {8'h00, conv_req_out.gain,
                conv_req_out.diff, conv_req_out.channel});
            if (cfg_m[s][4:0] < 5'd24)
                chk("avg", {14'h0, avg_m[cfg_m[s][4:0]]},
                    {14'h0, conv_req_out.sample_average_count});
            // averaging writes are refused while converting
            if (s == 2 && st[7]) wr(ADCSQ_OFS_DATA, {14'h0, ~avg_m[0]});
            else repeat (2) @(posedge clk_in);
            #1;
            chk("invalid", {15'h0, bad(cfg_m[s][4:0], cfg_m[s][5])},
                {15'h0, channel_invalid_out});
            v = s == 0 ? 14'h2000 : s == 1 ? 14'h1FFF : 14'($random(seed));
            @(posedge clk_in);
            conv_res_in <= '{valid: 1'b1, value: v};
            @(posedge clk_in);
            conv_res_in.valid <= 1'b0;
            dst = ovr ? cfg_m[s][12:8] : cfg_m[s][4:0];
            if (dst != ADCSQ_TEMP_ENTRY && dst < 5'd25) begin
                buf_m[dst] = fmt(v, cfg_m[s][6]);
                care[dst] = !bad(cfg_m[s][4:0], cfg_m[s][5]);
            end
        end
        repeat (4) @(posedge clk_in);
        rd(ADCSQ_OFS_STATUS, v16);
        chk("conv bit", 16'h0000, {15'h0, v16[ADCSQ_ST_CONV_BIT]});
        wr(ADCSQ_OFS_STATUS, 16'h0000);
        for (int i = 0; i < ADCSQ_NBUF; i++) begin
            rd(ADCSQ_OFS_DATA, v16);
            if (care[i] && i != 22) chk("result", buf_m[i], v16);
        end
        $display("conversion pass with override %0d done", ovr);
    endtask : pass
    task automatic cfg_load(input logic wide);
        logic [4:0] ch;
        logic [4:0] al;
        for (int i = 0; i < ADCSQ_NSLOT; i++) begin
            v16 = 16'($random(seed));
            ch = 5'($unsigned($random(seed)) % (wide ? 26 : 20));
            al = 5'($unsigned($random(seed)) % 24);
            if (al == ADCSQ_TEMP_ENTRY) al = 5'd24;
            if (!wide && ch >= 5'h08 && ch <= 5'h0F) v16[5] = 1'b0;
            cfg_m[i] = {1'b0, v16[14:13], al, v16[7:5], ch};
        end
        wr(ADCSQ_OFS_STATUS, 16'h0020);
        for (int i = 0; i < ADCSQ_NSLOT; i++)
            wr(ADCSQ_OFS_DATA, cfg_m[i] | 16'h8000);
        wr(ADCSQ_OFS_STATUS, 16'h0020);
        for (int i = 0; i < ADCSQ_NSLOT; i++) rdc("config", cfg_m[i]);
    endtask : cfg_load
    task automatic temp_run(input logic al, input logic ien);
        logic [13:0] v;
        v = 14'($random(seed));
        wr(ADCSQ_OFS_TEMP, {5'h00, ien, 5'h00, al, 4'h1});
        #1;
        chk("temp start", 16'h0001, {15'h0, temp_start_out});
        repeat (5) @(posedge clk_in);
        temp_res_in <= '{valid: 1'b1, value: v};
        @(posedge clk_in);
        temp_res_in.valid <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        chk("irq", {15'h0, ien}, {15'h0, temp_irq_out});
        rd(ADCSQ_OFS_FLAGS, v16);
        chk("ready", 16'h0001, {15'h0, v16[1]});
        wr(ADCSQ_OFS_STATUS, 16'h0016);
        rdc("temp entry", fmt(v, al));
        wr(ADCSQ_OFS_FLAGS, 16'h0000);
        repeat (2) @(posedge clk_in);
        #1;
        chk("irq off", 16'h0000, {15'h0, temp_irq_out});
        $display("temperature run align %0d done", al);
    endtask : temp_run
    // ===========================================
    // main sequence
    initial begin
        seed = 32'hfa0e;
        error_cnt = 0;
        n_tests = 0;
        bus_in = '0;
        conv_res_in = '0;
        temp_res_in = '0;
        reset_n_in = 1'b0;
        for (int i = 0; i < ADCSQ_NBUF; i++) care[i] = 1'b1;
        for (int i = 0; i < ADCSQ_NBUF; i++) buf_m[i] = 16'h0000;
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < ADCSQ_NBUF; i++) rdc("reset buf", 16'h0000);
        wr(ADCSQ_OFS_STATUS, 16'h0000);
        wr(ADCSQ_OFS_DATA, 16'hFFFF);
        wr(ADCSQ_OFS_STATUS, 16'h0000);
        rdc("ro buf", 16'h0000);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, v16);
        chk("unmapped", 16'h0000, v16);
        wr(ADCSQ_OFS_STATUS, 16'h0080);
        for (int i = 0; i < ADCSQ_NSLOT; i++) rdc("reset avg", 16'h0000);
        wr(ADCSQ_OFS_STATUS, 16'h0080);
        for (int i = 0; i < ADCSQ_NSLOT; i++) begin
            v16 = 16'($random(seed));
            avg_m[i] = v16[1:0];
            wr(ADCSQ_OFS_DATA, v16);
        end
        wr(ADCSQ_OFS_STATUS, 16'h0080);
        for (int i = 0; i < ADCSQ_NSLOT; i++) rdc("avg", {14'h0, avg_m[i]});
        $display("register test done");
        cfg_load(1'b0);
        pass(1'b0, 16'h00C0);
        wr(ADCSQ_OFS_STATUS, 16'h0080);
        rdc("avg kept", {14'h0, avg_m[0]});
        cfg_load(1'b1);
        pass(1'b1, 16'h0040);
        temp_run(1'b0, 1'b1);
        temp_run(1'b1, 1'b0);
        // a second reset in mid-run must clear what the runs left behind
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        wr(ADCSQ_OFS_STATUS, 16'h0080);
        rdc("avg after reset", 16'h0000);
        wr(ADCSQ_OFS_STATUS, 16'h0016);
        rdc("buf after reset", 16'h0000);
        $display("mid-run reset test done");
        complete_run();
    end
    // tests need well under 20000 cycles; a hang is cut short here
    initial begin
        #400000;
        error_cnt++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
